// >>> rtl/ddc_ctrl.sv
// Datapath control: registers, input staging, FIFO, sync, offset, delay
// Functional notes
// - Output samples delayed 0 to 3 converter periods, same on both channels.
// - Setting selects how many stages the incoming data passes before the core.
// - Mode selects dual, dual interleaved input, or single channel.
// - Each channel sleeps while its own sleep bit is set.
// - Single mode never forces channel_b asleep; software sets it.
// - Each channel has a 16-step gain setting driven to the converter.
// - Offset enable adds each working offset into its channel path.
// - Staged offsets copy to working offsets only on transfer command.
// - Mask bits suppress self-test, FIFO and setup/hold error reporting.
// - Failed core self-test sets a sticky flag until software clears it.
// - FIFO pointer overrun sets a sticky flag until software clears it.
// - Word other than 0xAAAA or 0x5555 sets sticky setup/hold flag.
// - A field selects which signal drives serial_readback_pin.
// - Serial port selectable between three-wire and four-wire readback.
// - Soft sync source uses only the software bit, pins ignored.
// - Software sync bit serves as sync event and transmit enable.
// - Sync reaches the output hold stage only when hold sync enabled.
// - Sync restarts the clock divider only when divider sync enabled.
// - Sync reloads the FIFO pointer only when FIFO sync enabled.
// - Self-test runs while its enable bit is set, failures flagged.
// - FIFO sync puts output pointer at offset -8 to -1 from input.
`include "ddc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ddc_ctrl (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [15:0] RDATA,
  input wire ddc_pkg::ddc_pair_t IN_DATA,
  input wire logic IN_VALID,
  input wire logic SYNC_PIN,
  input wire logic SER_RD_ACTIVE,
  input wire logic SER_RD_BIT,
  output ddc_pkg::ddc_pair_t OUT_DATA,
  output logic OUT_VALID,
  output logic [3:0] GAIN_A,
  output logic [3:0] GAIN_B,
  output logic SLEEP_A,
  output logic SLEEP_B,
  output logic CLK_DIV_SYNC,
  output logic SER_DATA_O,
  output logic SER_DATA_OE,
  output logic SERIAL_READBACK_PIN_O,
  output logic SERIAL_READBACK_PIN_OE
);
  import ddc_pkg::*;

  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  logic [1:0] rst_sr_q;
  logic rst_n;
  ddc_pair_t in_m_q, in_s_q;
  logic vld_m_q, vld_s_q, syn_m_q, syn_s_q;

  // Reset released through two flip-flops
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      rst_sr_q <= 2'h0;
    else
      rst_sr_q <= {rst_sr_q[0], 1'b1};
  end
  assign rst_n = rst_sr_q[1];

  // Two flops on the data, valid and sync pin inputs
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_m_q <= '0;
      in_s_q <= '0;
      vld_m_q <= 1'b0;
      vld_s_q <= 1'b0;
      syn_m_q <= 1'b0;
      syn_s_q <= 1'b0;
    end
    else
    begin
      in_m_q <= IN_DATA;
      in_s_q <= in_m_q;
      vld_m_q <= IN_VALID;
      vld_s_q <= vld_m_q;
      syn_m_q <= SYNC_PIN;
      syn_s_q <= syn_m_q;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  logic [15:0] cfg_q, gain_q, ofsa_q, ofsb_q, sync_q;
  logic [2:0] mask_q;
  ddc_err_t err_q, err_set;
  logic xfer_p;

  // Software writes; transfer bit is a pulse, not stored
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_q <= `DDC_CFG_RST;
      gain_q <= `DDC_GAIN_RST;
      ofsa_q <= `DDC_OFS_RST;
      ofsb_q <= `DDC_OFS_RST;
      sync_q <= `DDC_SYNC_RST;
      mask_q <= `DDC_MASK_RST;
    end
    else if (WR_STB)
    begin
      if (ADDR == `DDC_A_CFG)
        cfg_q <= WDATA;
      else if (ADDR == `DDC_A_GAIN)
        gain_q <= {8'h00, WDATA[7:0]};
      else if (ADDR == `DDC_A_OFSA)
        ofsa_q <= WDATA;
      else if (ADDR == `DDC_A_OFSB)
        ofsb_q <= WDATA;
      else if (ADDR == `DDC_A_SYNC)
        sync_q <= WDATA & 16'hFEFF;
      else if (ADDR == `DDC_A_MASK)
        mask_q <= WDATA[2:0];
    end
  end
  assign xfer_p = WR_STB && (ADDR == `DDC_A_SYNC) && WDATA[`DDC_SY_XFER];

  // Sticky errors: unmasked events set, write one clears, set wins
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
      err_q <= '0;
    else if (WR_STB && (ADDR == `DDC_A_ERR))
      err_q <= (err_q & ~WDATA[2:0]) | (err_set & ~mask_q);
    else
      err_q <= err_q | (err_set & ~mask_q);
  end

  // Static control outputs
  assign GAIN_A = gain_q[`DDC_GAIN_A];
  assign GAIN_B = gain_q[`DDC_GAIN_B];
  assign SLEEP_A = cfg_q[`DDC_CFG_SLPA];
  assign SLEEP_B = cfg_q[`DDC_CFG_SLPB];

  // ****************************************
  // Sync source and events
  // ****************************************
  logic sync_lvl, sync_prev_q, sync_ev, tx_en;

  // Soft source uses only the software bit
  assign sync_lvl = sync_q[`DDC_SY_SRC] ? sync_q[`DDC_SY_SOFT] : syn_s_q;
  assign tx_en = sync_lvl;
  assign sync_ev = sync_lvl && !sync_prev_q;

  // Edge memory for the sync event
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
      sync_prev_q <= 1'b0;
    else
      sync_prev_q <= sync_lvl;
  end

  // ****************************************
  // Converter rate divider
  // ****************************************
  logic [1:0] div_q;
  logic conv_en;

  // Divider restarts on sync only when enabled
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= 2'h0;
    else if (sync_ev && sync_q[`DDC_SY_CDIV])
      div_q <= 2'h0;
    else
      div_q <= div_q + 2'h1;
  end
  assign conv_en = (div_q == `DDC_DIV_LAST);
  assign CLK_DIV_SYNC = sync_ev && sync_q[`DDC_SY_CDIV];

  // ****************************************
  // Input clock stage delay and checks
  // ****************************************
  ddc_pair_t stg_d [0:3];
  logic stg_v [0:3];
  ddc_pair_t rx_w;
  logic rx_v;

  assign stg_d[0] = in_s_q;
  assign stg_v[0] = vld_s_q;
  // Extra register stages on the incoming words
  genvar g;
  generate
    for (g = 1; g < 4; g = g + 1)
    begin : g_stage
      always_ff @(posedge REF_CLK or negedge rst_n)
      begin
        if (!rst_n)
        begin
          stg_d[g] <= '0;
          stg_v[g] <= 1'b0;
        end
        else
        begin
          stg_d[g] <= stg_d[g-1];
          stg_v[g] <= stg_v[g-1];
        end
      end
    end
  endgenerate
  assign rx_w = stg_d[cfg_q[`DDC_CFG_CKD]];
  assign rx_v = stg_v[cfg_q[`DDC_CFG_CKD]];

  // True when a word matches neither check pattern
  function automatic logic bad_word(input logic [15:0] w);
    bad_word = (w != `DDC_PAT_A) && (w != `DDC_PAT_B);
  endfunction : bad_word

  assign err_set.sh = sync_q[`DDC_SY_SHCHK] && rx_v
                      && (bad_word(rx_w.a) || bad_word(rx_w.b));

  // ****************************************
  // Channel steering and self-test source
  // ****************************************
  logic ilv_ph_q;
  logic [15:0] ilv_hold_q, lfsr_q;
  logic st_on, wr_en;
  ddc_pair_t wr_w;

  // Interleave phase and held even word
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ilv_ph_q <= 1'b0;
      ilv_hold_q <= `DDC_ZERO;
    end
    else if (rx_v && cfg_q[`DDC_CFG_MODE] == `DDC_MODE_ILV)
    begin
      ilv_ph_q <= !ilv_ph_q;
      if (!ilv_ph_q)
        ilv_hold_q <= rx_w.a;
    end
    else if (cfg_q[`DDC_CFG_MODE] != `DDC_MODE_ILV)
      ilv_ph_q <= 1'b0;
  end

  // Pattern source for the core self-test
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
      lfsr_q <= `DDC_LFSR_SEED;
    else if (st_on && conv_en)
      lfsr_q <= {1'b0, lfsr_q[15:1]} ^ (lfsr_q[0] ? `DDC_LFSR_TAPS : `DDC_ZERO);
  end
  assign st_on = sync_q[`DDC_SY_STEST];

  // FIFO write word by mode
  always_comb
  begin
    wr_w = rx_w;
    wr_en = rx_v;
    if (st_on)
    begin
      wr_w = '{a: lfsr_q, b: ~lfsr_q};
      wr_en = conv_en;
    end
    else if (cfg_q[`DDC_CFG_MODE] == `DDC_MODE_ILV)
    begin
      wr_w = '{a: ilv_hold_q, b: rx_w.a};
      wr_en = rx_v && ilv_ph_q;
    end
    else if (cfg_q[`DDC_CFG_MODE] == `DDC_MODE_SINGLE)
      wr_w.b = `DDC_ZERO;
  end

  // ****************************************
  // FIFO with pointer offset on sync
  // ****************************************
  ddc_pair_t fifo_mem [0:7];
  ddc_pair_t rd_w;
  logic [3:0] wr_ptr_q, rd_ptr_q, level;
  logic fifo_ld;

  assign level = wr_ptr_q - rd_ptr_q;
  assign fifo_ld = sync_ev && sync_q[`DDC_SY_FIFO];
  assign rd_w = fifo_mem[rd_ptr_q[2:0]];

  // Storage
  always_ff @(posedge REF_CLK)
  begin
    if (wr_en)
      fifo_mem[wr_ptr_q[2:0]] <= wr_w;
  end

  // Pointers; reload places read side at the programmed offset
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0 - `DDC_FIFO_HALF;
    end
    else
    begin
      if (wr_en)
        wr_ptr_q <= wr_ptr_q + 4'h1;
      if (fifo_ld)
        rd_ptr_q <= wr_ptr_q - `DDC_FIFO_HALF
                    + {sync_q[`DDC_SY_FOFS_MSB], sync_q[`DDC_SY_FOFS]};
      else if (conv_en)
        rd_ptr_q <= rd_ptr_q + 4'h1;
    end
  end

  // Overrun: write into full or read from empty
  assign err_set.fifo = !fifo_ld && ((wr_en && level == `DDC_FIFO_FULL)
                        || (conv_en && level == 4'h0));

  // ****************************************
  // Self-test checker
  // ****************************************
  logic [3:0] st_cnt_q;

  // Count reads so stale entries drain before checking
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
      st_cnt_q <= 4'h0;
    else if (!st_on)
      st_cnt_q <= 4'h0;
    else if (conv_en && st_cnt_q != `DDC_ST_SETTLE)
      st_cnt_q <= st_cnt_q + 4'h1;
  end
  assign err_set.stest = st_on && conv_en && (st_cnt_q == `DDC_ST_SETTLE)
                         && (rd_w.a != ~rd_w.b);

  // ****************************************
  // Offset, hold and output delay
  // ****************************************
  logic [15:0] wofs_a_q, wofs_b_q;
  ddc_pair_t sum_w, dly_q [0:3];
  logic hold_en, vld_q;

  // Working offsets load only on transfer
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wofs_a_q <= `DDC_OFS_RST;
      wofs_b_q <= `DDC_OFS_RST;
    end
    else if (xfer_p)
    begin
      wofs_a_q <= ofsa_q;
      wofs_b_q <= ofsb_q;
    end
  end

  // Offset sum and sleep gating
  always_comb
  begin
    sum_w = rd_w;
    if (cfg_q[`DDC_CFG_OFSEN])
    begin
      sum_w.a = rd_w.a + wofs_a_q;
      sum_w.b = rd_w.b + wofs_b_q;
    end
    if (cfg_q[`DDC_CFG_SLPA])
      sum_w.a = `DDC_ZERO;
    if (cfg_q[`DDC_CFG_SLPB])
      sum_w.b = `DDC_ZERO;
  end

  assign hold_en = sync_q[`DDC_SY_HOLD];

  // Delay line in converter periods; hold sync flushes it
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 4; i++)
        dly_q[i] <= '0;
    end
    else if (sync_ev && hold_en)
    begin
      for (int i = 0; i < 4; i++)
        dly_q[i] <= '0;
    end
    else if (conv_en)
    begin
      dly_q[0] <= sum_w;
      for (int i = 1; i < 4; i++)
        dly_q[i] <= dly_q[i-1];
    end
  end

  // Output register; hold stage blanks while transmit is off
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      OUT_DATA <= '0;
      vld_q <= 1'b0;
    end
    else
    begin
      vld_q <= conv_en;
      if (conv_en)
        OUT_DATA <= (hold_en && !tx_en) ? '0 : dly_q[cfg_q[`DDC_CFG_DLY]];
    end
  end
  assign OUT_VALID = vld_q;

  // ****************************************
  // Serial readback pins
  // ****************************************
  logic sel_bit;

  // Signal routed to the readback pin; masked flags are not reported
  always_comb
  begin
    if (cfg_q[`DDC_CFG_SDO] == `DDC_SDO_SER)
      sel_bit = SER_RD_BIT;
    else if (cfg_q[`DDC_CFG_SDO] == `DDC_SDO_ERR)
      sel_bit = |(err_q & ~mask_q);
    else if (cfg_q[`DDC_CFG_SDO] == `DDC_SDO_SYNC)
      sel_bit = sync_lvl;
    else
      sel_bit = conv_en;
  end

  // Four-wire uses the dedicated pin; three-wire shares data
  assign SERIAL_READBACK_PIN_O = sel_bit;
  assign SERIAL_READBACK_PIN_OE = cfg_q[`DDC_CFG_SIF4];
  assign SER_DATA_O = SER_RD_BIT;
  assign SER_DATA_OE = !cfg_q[`DDC_CFG_SIF4] && SER_RD_ACTIVE;

  // ****************************************
  // Read port
  // ****************************************
  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
      RDATA <= `DDC_ZERO;
    else if (!RD_STB)
      RDATA <= `DDC_ZERO;
    else if (ADDR == `DDC_A_CFG)
      RDATA <= cfg_q; // factory_test_bit group held as written
    else if (ADDR == `DDC_A_GAIN)
      RDATA <= gain_q;
    else if (ADDR == `DDC_A_OFSA)
      RDATA <= ofsa_q;
    else if (ADDR == `DDC_A_OFSB)
      RDATA <= ofsb_q;
    else if (ADDR == `DDC_A_SYNC)
      RDATA <= sync_q;
    else if (ADDR == `DDC_A_MASK)
      RDATA <= {13'h0000, mask_q};
    else if (ADDR == `DDC_A_ERR)
      RDATA <= {13'h0000, err_q};
    else if (ADDR == `DDC_A_STAT)
      RDATA <= {10'h000, level, tx_en, sync_lvl};
    else
      RDATA <= `DDC_ZERO;
  end
endmodule : ddc_ctrl
`default_nettype wire

// >>> rtl/ddc_defs.svh
// Constants of the dual converter datapath control block
`ifndef DDC_DEFS_SVH
`define DDC_DEFS_SVH
// Register addresses
`define DDC_A_CFG 4'h0
`define DDC_A_GAIN 4'h1
`define DDC_A_OFSA 4'h2
`define DDC_A_OFSB 4'h3
`define DDC_A_SYNC 4'h4
`define DDC_A_MASK 4'h5
`define DDC_A_ERR 4'h6
`define DDC_A_STAT 4'h7
// Configuration fields
`define DDC_CFG_DLY 1:0
`define DDC_CFG_CKD 3:2
`define DDC_CFG_MODE 5:4
`define DDC_CFG_SLPA 6
`define DDC_CFG_SLPB 7
`define DDC_CFG_OFSEN 8
`define DDC_CFG_SIF4 9
`define DDC_CFG_SDO 11:10
`define DDC_CFG_TEST 15:12
`define DDC_GAIN_A 3:0
`define DDC_GAIN_B 7:4
// Sync register fields
`define DDC_SY_SRC 0
`define DDC_SY_SOFT 1
`define DDC_SY_HOLD 2
`define DDC_SY_CDIV 3
`define DDC_SY_FIFO 4
`define DDC_SY_FOFS 7:5
`define DDC_SY_FOFS_MSB 7
`define DDC_SY_XFER 8
`define DDC_SY_STEST 9
`define DDC_SY_SHCHK 10
// Reset values
`define DDC_CFG_RST 16'h0000
`define DDC_GAIN_RST 16'h00FF
`define DDC_SYNC_RST 16'h0000
`define DDC_OFS_RST 16'h0000
`define DDC_MASK_RST 3'h0
// Modes and readback selections
`define DDC_MODE_DUAL 2'h0
`define DDC_MODE_ILV 2'h1
`define DDC_MODE_SINGLE 2'h2
`define DDC_SDO_SER 2'h0
`define DDC_SDO_ERR 2'h1
`define DDC_SDO_SYNC 2'h2
`define DDC_SDO_CONV 2'h3
// Data constants
`define DDC_PAT_A 16'hAAAA
`define DDC_PAT_B 16'h5555
`define DDC_ZERO 16'h0000
`define DDC_DIV_LAST 2'h3
`define DDC_FIFO_HALF 4'h4
`define DDC_FIFO_FULL 4'h8
`define DDC_ST_SETTLE 4'h8
`define DDC_LFSR_SEED 16'hACE1
`define DDC_LFSR_TAPS 16'hB400
`endif

// >>> rtl/ddc_pkg.sv
// Types shared by the datapath control block
package ddc_pkg;
  // One sample for each channel
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
  } ddc_pair_t;
  // Sticky error flags
  typedef struct packed {
    logic sh;
    logic fifo;
    logic stest;
  } ddc_err_t;
endpackage : ddc_pkg

// >>> tb/ddc_ctrl_properties.sv
// Port-level checker of the datapath control block
`timescale 1ns/1ps
`default_nettype none
module ddc_ctrl_properties (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR_STB,
  input wire logic OUT_VALID,
  input wire logic [3:0] GAIN_A,
  input wire logic [3:0] GAIN_B,
  input wire logic SLEEP_A,
  input wire logic SLEEP_B,
  input wire logic CLK_DIV_SYNC,
  input wire logic SER_RD_ACTIVE,
  input wire logic SER_DATA_OE,
  input wire logic SERIAL_READBACK_PIN_OE
);
  // ****************************************
  // Helper copy of the last write data
  // ****************************************
  logic [15:0] wd_q;
  logic cfg_wr;
  logic gain_wr;
  // Write data one cycle back, for write effects
  always_ff @(posedge REF_CLK)
  begin
    wd_q <= WDATA;
  end
  // Strobe decodes
  assign cfg_wr = WR_STB && (ADDR == 4'h0);
  assign gain_wr = WR_STB && (ADDR == 4'h1);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);
  AST_SLEEP_LOAD: assert property (cfg_wr |=> {SLEEP_B, SLEEP_A} == wd_q[7:6])
    else $error("sleep outputs differ from written bits");
  AST_SINGLE_NO_SLEEP: assert property (cfg_wr && WDATA[5:4] == 2'h2 && !WDATA[7] |=> !SLEEP_B)
    else $error("channel b asleep in single mode without its bit");
  AST_GAIN_LOAD: assert property (gain_wr |=> GAIN_A == wd_q[3:0] && GAIN_B == wd_q[7:4])
    else $error("gain outputs differ from written value");
  AST_GAIN_HOLD: assert property (!gain_wr |=> $stable(GAIN_A) && $stable(GAIN_B))
    else $error("gain changed without a gain write");
  AST_PIN_OE_MODE: assert property (cfg_wr |=> SERIAL_READBACK_PIN_OE == wd_q[9])
    else $error("readback pin enable differs from wire mode");
  AST_SHARED_OE: assert property (SER_DATA_OE |-> SER_RD_ACTIVE)
    else $error("shared data pin driven outside a read");
  AST_ONE_DRIVER: assert property (SER_RD_ACTIVE |-> SER_DATA_OE != SERIAL_READBACK_PIN_OE)
    else $error("readback not on exactly one pin");
  AST_DIV_PULSE: assert property (CLK_DIV_SYNC |=> !CLK_DIV_SYNC)
    else $error("divider sync longer than one cycle");
  AST_OUT_PULSE: assert property (OUT_VALID |=> !OUT_VALID)
    else $error("output strobe longer than one cycle");
endmodule : ddc_ctrl_properties
`default_nettype wire

// >>> tb/ddc_src_model.sv
// Behavioural sample source on the converter input lanes
`timescale 1ns/1ps
`default_nettype none
module ddc_src_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic zeros,
  input wire logic bad,
  input wire logic sync_req,
  output ddc_pkg::ddc_pair_t in_data,
  output logic in_valid,
  output logic sync_pin
);
  import ddc_pkg::*;
  // ****************************************
  // Word stream
  // ****************************************
  logic [1:0] ph_q;
  logic alt_q;
  logic [15:0] w;
  // Word for this slot: check pattern, zero, or a broken word
  assign w = bad ? 16'h1234 : (zeros ? 16'h0000 : (alt_q ? 16'h5555 : 16'hAAAA));
  // One word every four clocks; lanes scrambled between words
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ph_q <= 2'h0;
      alt_q <= 1'b0;
      in_valid <= 1'b0;
      in_data <= 32'h0000_0000;
    end
    else
    begin
      ph_q <= ph_q + 2'h1;
      in_valid <= (ph_q == 2'h0);
      if (ph_q == 2'h0)
      begin
        alt_q <= !alt_q;
        in_data <= {w, w};
      end
      else
      begin
        in_data <= ~in_data;
      end
    end
  end
  // External sync level follows the bench request
  always_ff @(posedge clk)
  begin
    sync_pin <= sync_req;
  end
endmodule : ddc_src_model
`default_nettype wire

// >>> tb/ddc_ctrl_tb.sv
// Self-checking bench of the datapath control block
`timescale 1ns/1ps
`default_nettype none
module ddc_ctrl_tb;
  import ddc_pkg::*;
  logic ref_clk, rst_b, wr_stb, rd_stb, in_valid, sync_pin, ser_act, ser_bit, zeros, bad, sync_req;
  logic [3:0] addr, gain_a, gain_b;
  logic [15:0] wdata, rdata, d;
  ddc_pair_t in_data, out_data;
  logic out_valid, sleep_a, sleep_b, div_sync, sd_o, sd_oe, rb_o, rb_oe;
  int failures = 0;
  int n_checks = 0;
  int cyc_n = 0;
  int n_div = 0;
  logic [15:0] rst_v [0:6] = '{16'h0000, 16'h00FF, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] cfg_v [0:2] = '{16'h0060, 16'h00A0, 16'h0010};
  ddc_ctrl i_dut (.REF_CLK(ref_clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
    .RD_STB(rd_stb), .RDATA(rdata), .IN_DATA(in_data), .IN_VALID(in_valid), .SYNC_PIN(sync_pin),
    .SER_RD_ACTIVE(ser_act), .SER_RD_BIT(ser_bit), .OUT_DATA(out_data), .OUT_VALID(out_valid),
    .GAIN_A(gain_a), .GAIN_B(gain_b), .SLEEP_A(sleep_a), .SLEEP_B(sleep_b), .CLK_DIV_SYNC(div_sync),
    .SER_DATA_O(sd_o), .SER_DATA_OE(sd_oe), .SERIAL_READBACK_PIN_O(rb_o), .SERIAL_READBACK_PIN_OE(rb_oe));
  ddc_src_model i_src (.clk(ref_clk), .rst_b(rst_b), .zeros(zeros), .bad(bad), .sync_req(sync_req),
    .in_data(in_data), .in_valid(in_valid), .sync_pin(sync_pin));
  // ****************************************
  // Clock, timeout and bus tasks
  // ****************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Hang guard and divider sync pulse counter
  always @(posedge ref_clk)
  begin
    cyc_n++;
    if (div_sync === 1'b1) n_div++;
    if (cyc_n == 20000)
    begin
      failures++;
      print_verdict();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    v = rdata;
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic pin_rise();
    @(posedge ref_clk);
    sync_req <= 1'b0;
    cyc(8);
    @(posedge ref_clk);
    sync_req <= 1'b1;
    cyc(8);
  endtask : pin_rise
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // ****************************************
  // Test sequence; factory test field always written zero
  // ****************************************
  initial
  begin
    {rst_b, wr_stb, rd_stb, ser_act, ser_bit, zeros, bad, sync_req} = 8'h00;
    addr = 4'h0;
    wdata = 16'h0000;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 7; i++)
    begin
      rd(i[3:0], d);
      chk("reset value", {16'h0000, d}, {16'h0000, rst_v[i]});
    end
    rd(4'hC, d);
    chk("unmapped read", {16'h0000, d}, 32'h0000_0000);
    for (int i = 0; i < 16; i++)
    begin
      wr(4'h1, {8'hFF, i[3:0], ~i[3:0]});
      chk("gain pins", {24'h00_0000, gain_b, gain_a}, {24'h00_0000, i[3:0], ~i[3:0]});
      rd(4'h1, d);
      chk("gain reg", {16'h0000, d}, {24'h00_0000, i[3:0], ~i[3:0]});
    end
    foreach (cfg_v[i])
    begin
      wr(4'h0, cfg_v[i]);
      chk("sleep pins", {30'h0, sleep_b, sleep_a}, {30'h0, cfg_v[i][7:6]});
      rd(4'h0, d);
      chk("cfg reg", {16'h0000, d}, {16'h0000, cfg_v[i]});
    end
    @(posedge ref_clk);
    ser_act <= 1'b1;
    ser_bit <= 1'b1;
    wr(4'h0, 16'h0200);
    chk("four wire", {29'h0, sd_oe, rb_oe, rb_o}, 32'h0000_0003);
    @(posedge ref_clk);
    ser_bit <= 1'b0;
    #1;
    chk("serial bit", {31'h0, rb_o}, 32'h0000_0000);
    wr(4'h0, 16'h0000);
    chk("three wire", {29'h0, sd_oe, rb_oe, sd_o}, 32'h0000_0004);
    @(posedge ref_clk);
    ser_act <= 1'b0;
    wr(4'h0, 16'h0400);
    wr(4'h5, 16'h0003);
    wr(4'h4, 16'h0400);
    cyc(20);
    wr(4'h6, 16'h0007);
    cyc(20);
    rd(4'h6, d);
    chk("sh flag clean", {16'h0000, d & 16'h0004}, 32'h0000_0000);
    @(posedge ref_clk);
    bad <= 1'b1;
    repeat (4) @(posedge ref_clk);
    bad <= 1'b0;
    cyc(20);
    rd(4'h6, d);
    chk("sh flag set", {16'h0000, d & 16'h0004}, 32'h0000_0004);
    chk("error pin", {31'h0, rb_o}, 32'h0000_0001);
    wr(4'h5, 16'h0007);
    chk("masked pin", {31'h0, rb_o}, 32'h0000_0000);
    wr(4'h5, 16'h0003);
    chk("unmasked pin", {31'h0, rb_o}, 32'h0000_0001);
    wr(4'h6, 16'h0004);
    cyc(20);
    rd(4'h6, d);
    chk("sh flag cleared", {16'h0000, d & 16'h0004}, 32'h0000_0000);
    wr(4'h0, 16'h0800);
    wr(4'h4, 16'h0009);
    wr(4'h4, 16'h000B);
    cyc(8);
    chk("soft div sync", n_div, 1);
    chk("soft level", {31'h0, rb_o}, 32'h0000_0001);
    rd(4'h7, d);
    chk("tx and sync", {30'h0, d[1:0]}, 32'h0000_0003);
    pin_rise();
    chk("pins ignored", n_div, 1);
    wr(4'h4, 16'h0009);
    cyc(8);
    chk("pin high ignored", {31'h0, rb_o}, 32'h0000_0000);
    wr(4'h4, 16'h0000);
    cyc(8);
    chk("pin level", {31'h0, rb_o}, 32'h0000_0001);
    pin_rise();
    chk("div sync off", n_div, 1);
    wr(4'h4, 16'h0008);
    pin_rise();
    chk("div sync on", n_div, 2);
    @(posedge ref_clk);
    zeros <= 1'b1;
    wr(4'h0, 16'h0100);
    wr(4'h2, 16'h1234);
    wr(4'h3, 16'h0ABC);
    cyc(60);
    chk("staged only", out_data, 32'h0000_0000);
    wr(4'h4, 16'h0100);
    cyc(60);
    chk("offset sum", out_data, 32'h1234_0ABC);
    wr(4'h2, 16'h7777);
    cyc(60);
    chk("no transfer", out_data, 32'h1234_0ABC);
    rd(4'h4, d);
    chk("transfer bit", {16'h0000, d}, 32'h0000_0000);
    wr(4'h4, 16'h0004);
    @(posedge ref_clk);
    sync_req <= 1'b0;
    cyc(20);
    chk("hold blank", out_data, 32'h0000_0000);
    wr(4'h4, 16'h0000);
    wr(4'h0, 16'h0140);
    cyc(60);
    chk("sleep lane a", out_data, 32'h0000_0ABC);
    wr(4'h0, 16'h0000);
    cyc(60);
    chk("offset off", out_data, 32'h0000_0000);
    wr(4'h5, 16'h0006);
    wr(4'h4, 16'h0200);
    cyc(80);
    rd(4'h6, d);
    chk("self test clean", {16'h0000, d & 16'h0001}, 32'h0000_0000);
    wr(4'h4, 16'h0071);
    wr(4'h4, 16'h0073);
    cyc(8);
    rd(4'h7, d);
    chk("fifo offset", {31'h0, d[5:2] < 4'h3}, 32'h0000_0001);
    print_verdict();
  end
endmodule : ddc_ctrl_tb
bind ddc_ctrl ddc_ctrl_properties i_props (.REF_CLK(REF_CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
  .WR_STB(WR_STB), .OUT_VALID(OUT_VALID), .GAIN_A(GAIN_A), .GAIN_B(GAIN_B), .SLEEP_A(SLEEP_A),
  .SLEEP_B(SLEEP_B), .CLK_DIV_SYNC(CLK_DIV_SYNC), .SER_RD_ACTIVE(SER_RD_ACTIVE),
  .SER_DATA_OE(SER_DATA_OE), .SERIAL_READBACK_PIN_OE(SERIAL_READBACK_PIN_OE));
`default_nettype wire
